// >>> adc_sample_sequencer.sv
// Acquisition and conversion sequencer with its parallel register interface
//
// Overview of operation
// - Acquire 20 clock cycles after a start, whatever the group size.
// - Hold all four inputs together, then convert selected ones in turn.
// - Each channel takes 40 cycles; a group ends 20 plus 40n after start.
// - A group always has at least two channels.
// - Only convert_start begins a group; register writes never do.
// - After reset only phase two and phase three are converted.
// - Config bit 3 selects three-phase mode with all phase inputs.
// - Finished results read in any order without disturbing each other.
// - Config bit 7 enables the end-of-conversion interrupt.
// - With interrupt enabled, request goes active when a group completes.
// - Status bit 0 shows the converter completed a group, even with the interrupt disabled.
// - Reading the status register clears its flag bits.
// - Each channel has its own result register.
// - Result is 11-bit two's complement, left-justified, LSB zero.
// - 20 cycles of reacquisition after a group; starts during it are deferred.
`timescale 1ns/1ps
module adc_sample_sequencer (
  // Clock and reset
  input  wire logic           clk_sys,
  input  wire logic           reset_n,
  // Parallel register bus
  input  wire logic           cs_n,
  input  wire logic           rd_n,
  input  wire logic           wr_n,
  input  wire seq_pkg::addr_t addr,
  input  wire seq_pkg::data_t data_in,
  output      seq_pkg::data_t data_out,
  output      logic           data_oe,
  // Conversion request
  input  wire logic           convert_start,
  // Analog front end and converter
  output      logic           sha_hold,
  output      seq_pkg::chan_t adc_channel,
  input  wire seq_pkg::code_t adc_code,
  // Interrupt request, active low
  output      logic           irq_n
);
  import seq_pkg::*;

  // Sequencer registers
  seq_state_e state_r;
  seq_state_e state_nxt;
  cnt_t       cnt_r;
  cnt_t       cnt_nxt;
  chan_t      chan_r;
  chan_t      chan_nxt;
  logic       pend_r;
  logic       pend_nxt;
  logic       grp_aux_r;
  logic       grp_aux_nxt;
  logic       start_q_r;
  logic       group_done;
  result_wr_s res_wr;

  // Bus registers
  data_t      cfg_r;
  data_t      data_out_r;
  addr_t      addr_q_r;
  logic       rd_act_q_r;
  logic       wr_act_q_r;
  logic       rd_load_r;
  logic       adc_flag_r;
  data_t      store_rd_data;

  // Bus strobes: each access acts once, on its first sampled cycle
  wire rd_act    = !cs_n && !rd_n;
  wire wr_act    = !cs_n && !wr_n;
  wire rd_start  = rd_act && !rd_act_q_r;
  wire wr_start  = wr_act && !wr_act_q_r;
  wire cfg_write = wr_start && (addr == ADDR_CHANNEL_CONFIG);
  wire stat_read = rd_load_r && (addr_q_r == ADDR_SOURCE_STATUS);
  wire is_result = (addr_q_r[ADDR_W-1:2] == 2'h0);

  // Start edge; a held level does not start a second group
  wire start_rise = convert_start && !start_q_r;

  // Group shape taken from config at launch
  wire cfg_three  = cfg_r[CFG_THREE_PHASE_BIT];
  wire cfg_aux    = cfg_r[CFG_AUX_BIT];
  wire cnt_acq_end  = (cnt_r == ACQ_CYCLES - 6'h01);
  wire cnt_conv_end = (cnt_r == CONV_CYCLES - 6'h01);
  wire cnt_rq_end   = (cnt_r == REACQ_CYCLES - 6'h01);
  wire last_chan    = (chan_r == CH_AUXILIARY) || ((chan_r == CH_PHASE_THREE) && !grp_aux_r);
  wire launch_req   = start_rise || pend_r;

  // Default mode starts at phase two so even the smallest group holds two channels
  wire chan_t first_chan = cfg_three ? CH_PHASE_ONE : CH_PHASE_TWO;

  // Sequencer next state
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    chan_nxt    = chan_r;
    pend_nxt    = pend_r;
    grp_aux_nxt = grp_aux_r;
    group_done  = 1'b0;
    case (state_r)
      ST_REACQ: begin
        // Inputs settle again; a start seen here waits instead of being lost
        cnt_nxt  = cnt_r + 6'h01;
        pend_nxt = pend_r || start_rise;
        if (cnt_rq_end) begin
          state_nxt = ST_IDLE;
          cnt_nxt   = '0;
        end
      end
      ST_IDLE: begin
        if (launch_req) begin
          // Only the pin launches a group
          state_nxt   = ST_ACQ;
          cnt_nxt     = '0;
          pend_nxt    = 1'b0;
          chan_nxt    = first_chan;
          grp_aux_nxt = cfg_aux;
        end
      end
      ST_ACQ: begin
        // Fixed acquisition regardless of group size; starts here are ignored
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_acq_end) begin
          state_nxt = ST_CONV;
          cnt_nxt   = '0;
        end
      end
      ST_CONV: begin
        // One converter walks the held channels in order
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_conv_end) begin
          cnt_nxt = '0;
          if (last_chan) begin
            state_nxt  = ST_REACQ;
            group_done = 1'b1;
          end else begin
            chan_nxt = chan_r + 2'h1;
          end
        end
      end
      default: begin
        state_nxt = ST_REACQ;
        cnt_nxt   = '0;
      end
    endcase
  end

  // Result written in the last conversion cycle, left-justified with LSB zero
  assign res_wr.en   = (state_r == ST_CONV) && cnt_conv_end;
  assign res_wr.idx  = chan_r;
  assign res_wr.data = {adc_code, 1'b0};

  // Sequencer registers; reset starts with a reacquire interval
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= ST_REACQ;
      cnt_r     <= '0;
      chan_r    <= CH_PHASE_TWO;
      pend_r    <= 1'b0;
      grp_aux_r <= 1'b0;
      start_q_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      chan_r    <= chan_nxt;
      pend_r    <= pend_nxt;
      grp_aux_r <= grp_aux_nxt;
      start_q_r <= convert_start;
    end
  end

  // Hold stays on through every conversion of the group
  assign sha_hold    = (state_r == ST_CONV);
  assign adc_channel = chan_r;

  // Result registers
  result_store u_store (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .wr      (res_wr),
    .rd_idx  (addr[1:0]),
    .rd_data (store_rd_data)
  );

  // Config register; only bits 2, 3 and 7 are stored, so all other bits always read zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= CFG_RESET;
    end else if (cfg_write) begin
      cfg_r <= data_in & CFG_WRITE_MASK;
    end
  end

  // Completion flag: a new completion wins over the clearing read
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      adc_flag_r <= 1'b0;
    end else if (group_done) begin
      adc_flag_r <= 1'b1;
    end else if (stat_read) begin
      adc_flag_r <= 1'b0;
    end
  end

  // Read data selection; store data lag one cycle behind the address
  wire data_t stat_word = data_t'({adc_flag_r}) << STAT_ADC_BIT;
  wire data_t rd_mux    = is_result ? store_rd_data :
                          (addr_q_r == ADDR_CHANNEL_CONFIG) ? cfg_r :
                          (addr_q_r == ADDR_SOURCE_STATUS) ? stat_word : 12'h000;

  // Bus tracking; read data are latched once and held for the whole strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_act_q_r <= 1'b0;
      wr_act_q_r <= 1'b0;
      rd_load_r  <= 1'b0;
      addr_q_r   <= '0;
      data_out_r <= '0;
    end else begin
      rd_act_q_r <= rd_act;
      wr_act_q_r <= wr_act;
      rd_load_r  <= rd_start;
      if (rd_start) begin
        addr_q_r <= addr;
      end
      if (rd_load_r) begin
        data_out_r <= rd_mux;
      end
    end
  end

  assign data_out = data_out_r;
  assign data_oe  = rd_act;

  // Interrupt only while enabled and the flag is set
  assign irq_n = !(adc_flag_r && cfg_r[CFG_IRQ_EN_BIT]);

endmodule

// >>> seq_pkg.sv
// Constants, types and register map shared by the sample sequencer files
package seq_pkg;

  // Bus and data widths
  localparam int DATA_W = 12;
  localparam int CODE_W = 11;
  localparam int ADDR_W = 4;
  localparam int NUM_CH = 4;
  localparam int CNT_W  = 6;

  typedef logic [DATA_W-1:0] data_t;
  typedef logic [CODE_W-1:0] code_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [1:0]        chan_t;
  typedef logic [CNT_W-1:0]  cnt_t;

  // Register offsets on the parallel bus
  localparam addr_t ADDR_RESULT_PHASE_ONE   = 4'h0;
  localparam addr_t ADDR_RESULT_PHASE_TWO   = 4'h1;
  localparam addr_t ADDR_RESULT_PHASE_THREE = 4'h2;
  localparam addr_t ADDR_RESULT_AUXILIARY   = 4'h3;
  localparam addr_t ADDR_CHANNEL_CONFIG     = 4'h4;
  localparam addr_t ADDR_SOURCE_STATUS      = 4'h5;

  // Channel indices, in conversion order
  localparam chan_t CH_PHASE_ONE   = 2'h0;
  localparam chan_t CH_PHASE_TWO   = 2'h1;
  localparam chan_t CH_PHASE_THREE = 2'h2;
  localparam chan_t CH_AUXILIARY   = 2'h3;

  // Field positions in channel_config_reg and source_status_reg
  localparam int CFG_AUX_BIT         = 2;
  localparam int CFG_THREE_PHASE_BIT = 3;
  localparam int CFG_IRQ_EN_BIT      = 7;
  localparam int STAT_ADC_BIT        = 0;

  // Reset value and writable bits of channel_config_reg, and the result reset value
  localparam data_t CFG_RESET      = 12'h000;
  localparam data_t CFG_WRITE_MASK = 12'h08C;
  localparam data_t RESULT_RESET   = 12'h000;

  // Sequence timing in system clock cycles
  localparam cnt_t ACQ_CYCLES   = 6'h14;
  localparam cnt_t CONV_CYCLES  = 6'h28;
  localparam cnt_t REACQ_CYCLES = 6'h14;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_REACQ = 2'b00,
    ST_IDLE  = 2'b01,
    ST_ACQ   = 2'b10,
    ST_CONV  = 2'b11
  } seq_state_e;

  // One result write into the result store
  typedef struct packed {
    logic  en;
    chan_t idx;
    data_t data;
  } result_wr_s;

endpackage

// >>> result_store.sv
// Four dedicated result registers with a registered read port
`timescale 1ns/1ps
module result_store (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  // Write from the sequencer
  input  wire seq_pkg::result_wr_s wr,
  // Read port
  input  wire seq_pkg::chan_t     rd_idx,
  output      seq_pkg::data_t     rd_data
);
  import seq_pkg::*;

  data_t mem   [NUM_CH];
  data_t rd_data_r;

  // One register per channel; a write touches only its own entry
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_entry
      wire hit = wr.en && (wr.idx == chan_t'(i));
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          mem[i] <= RESULT_RESET;
        end else if (hit) begin
          mem[i] <= wr.data;
        end
      end
    end
  endgenerate

  // Reads have no side effect, so any order is safe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_r <= RESULT_RESET;
    end else begin
      rd_data_r <= mem[rd_idx];
    end
  end

  assign rd_data = rd_data_r;

endmodule

// >>> adc_front_model.sv
// Converter front end model: four inputs held together, one code out
`timescale 1ns/1ps
module adc_front_model (
  // Clock and hold control
  input  wire logic                 clk_sys,
  input  wire logic                 sha_hold,
  input  wire seq_pkg::chan_t       adc_channel,
  // Analog levels in, code out
  input  wire seq_pkg::code_t [3:0] level,
  output      seq_pkg::code_t       adc_code
);
  import seq_pkg::*;
  code_t [3:0] held_r;
  code_t       junk_r = 11'h2aa;
  logic        hold_q_r = 1'b0;

  // All four captured in one edge; later level changes must not leak in
  // Plain always, since the toggling filler starts from a declared value
  always @(posedge clk_sys) begin
    hold_q_r <= sha_hold;
    junk_r   <= ~junk_r;
    if (sha_hold && !hold_q_r) begin
      held_r <= level;
    end
  end

  // Outside the hold the code toggles, so a stray sample shows up
  assign adc_code = sha_hold ? held_r[adc_channel] : junk_r;
endmodule

// >>> adc_seq_monitor.sv
// Port-level checks of the sequencer
`timescale 1ns/1ps
module adc_seq_monitor (
  // Clock and reset
  input wire logic           clk_sys,
  input wire logic           reset_n,
  // Bus
  input wire logic           cs_n,
  input wire logic           rd_n,
  input wire seq_pkg::addr_t addr,
  input wire seq_pkg::data_t data_out,
  input wire logic           data_oe,
  // Converter and interrupt
  input wire logic           sha_hold,
  input wire seq_pkg::chan_t adc_channel,
  input wire logic           irq_n
);
  import seq_pkg::*;
  int unsigned hold_cnt_r;
  int unsigned low_cnt_r;
  logic        rd_q_r;
  wire logic   rd_take = !cs_n && !rd_n && !rd_q_r;

  // Lengths of hold and idle stretches, and strobe history
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt_r <= 0;
      low_cnt_r  <= 0;
      rd_q_r     <= 1'b0;
    end else begin
      hold_cnt_r <= sha_hold ? hold_cnt_r + 1 : 0;
      low_cnt_r  <= sha_hold ? 0 : low_cnt_r + 1;
      rd_q_r     <= !cs_n && !rd_n;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_stat_rd;
    rd_take && addr == ADDR_SOURCE_STATUS;
  endsequence
  property p_oe; data_oe == (!cs_n && !rd_n); endproperty
  property p_len; $fell(sha_hold) && $past(reset_n) |-> hold_cnt_r inside {80, 120, 160}; endproperty
  property p_acq; $rose(sha_hold) |-> low_cnt_r >= 40 && adc_channel != CH_AUXILIARY; endproperty
  property p_step; $changed(adc_channel) && sha_hold |-> hold_cnt_r % 40 == 0; endproperty
  property p_order; $changed(adc_channel) && sha_hold && hold_cnt_r != 0 |-> adc_channel == $past(adc_channel) + 2'h1;
  endproperty
  property p_irq_set; $fell(irq_n) |-> $fell(sha_hold); endproperty
  property p_irq_clr; s_stat_rd |-> ##2 (irq_n || $fell(sha_hold)); endproperty
  property p_unmapped; rd_take && addr >= 4'h6 |-> ##2 data_out == 12'h000; endproperty

  a_oe: assert property (p_oe) else $error("data enable wrong");
  a_len: assert property (p_len) else $error("group length wrong");
  a_acq: assert property (p_acq) else $error("acquire too short");
  a_step: assert property (p_step) else $error("channel step off");
  a_order: assert property (p_order) else $error("channel order wrong");
  a_irq_set: assert property (p_irq_set) else $error("irq without completion");
  a_irq_clr: assert property (p_irq_clr) else $error("status read kept irq");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// >>> tb_adc_sample_sequencer.sv
// Self-checking bench for the sample sequencer
`timescale 1ns/1ps
module tb_adc_sample_sequencer;
  import seq_pkg::*;
  logic        clk_sys = 1'b0, reset_n = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  logic        convert_start = 1'b0, got = 1'b0, data_oe, sha_hold, irq_n;
  addr_t       addr = 4'h0;
  data_t       data_in = 12'h000, data_out, cfg_r = CFG_RESET, exp_r [4] = '{default: RESULT_RESET};
  chan_t       adc_channel;
  code_t       adc_code;
  code_t [3:0] level = '0;
  data_t       q [$];
  int          err_count = 0, comparisons = 0, cyc = 0;

  adc_sample_sequencer i_adc_sample_sequencer (.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .convert_start(convert_start), .sha_hold(sha_hold), .adc_channel(adc_channel), .adc_code(adc_code),
    .irq_n(irq_n));
  adc_front_model i_adc_front_model (.clk_sys(clk_sys), .sha_hold(sha_hold), .adc_channel(adc_channel),
    .level(level), .adc_code(adc_code));

  initial forever #25 clk_sys = ~clk_sys;

  task automatic chk(input data_t seen, input data_t exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, well above the roughly 1400 cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  // Read data is compared against the oldest note once it has settled
  always @(posedge clk_sys) if (got) begin
    got <= 1'b0;
    chk(data_out, q.pop_front());
  end

  // Read: take edge, load edge, then release
  task automatic rd(input addr_t a, input data_t e);
    @(posedge clk_sys);
    {cs_n, rd_n, addr} <= {2'b00, a};
    q.push_back(e);
    repeat (2) @(posedge clk_sys);
    {cs_n, rd_n, got} <= 3'b111;
  endtask

  // Zero-wait write; released data shows its inverse
  task automatic wr(input addr_t a, input data_t d);
    @(posedge clk_sys);
    {cs_n, wr_n, addr, data_in} <= {2'b00, a, d};
    @(posedge clk_sys);
    {cs_n, wr_n, data_in} <= {2'b11, ~d};
  endtask

  // One group; a second start and new levels land mid-conversion
  task automatic grp(input int lo, input int hi, input bit reads);
    int k, a, h, n;
    code_t [3:0] r;
    k = 0;
    a = 0;
    h = 0;
    n = (cfg_r[2] ? 3 : 2) - (cfg_r[3] ? 0 : 1) + 1;
    r = 44'({$urandom(), $urandom()});
    @(posedge clk_sys);
    // Single-clock start, shaped like the PWM period marker a host may forward
    {convert_start, level} <= {1'b1, r};
    @(posedge clk_sys);
    convert_start <= 1'b0;
    while (!(h > 0 && !sha_hold) && k < 400) begin
      @(posedge clk_sys);
      k++;
      h += sha_hold;
      convert_start <= sha_hold && a == 0;
      if (sha_hold && a == 0) begin
        a = k;
        level <= ~level;
      end
    end
    chk(data_t'(a >= lo && a <= hi), 12'h001);
    chk(data_t'(k - a), data_t'(40 * n));
    chk(irq_n, !cfg_r[7]);
    for (int c = cfg_r[3] ? 0 : 1; c <= (cfg_r[2] ? 3 : 2); c++) exp_r[c] = {r[c], 1'b0};
    if (reads) begin
      for (int c = 3; c >= 0; c--) rd(addr_t'(c), exp_r[c]);
      rd(ADDR_SOURCE_STATUS, 12'h001);
      rd(ADDR_SOURCE_STATUS, 12'h000);
      chk(irq_n, 1'b1);
    end
  endtask

  initial begin
    data_t wv;
    void'($urandom(93));
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    // Reset opens with a reacquire stretch; the first group below expects no deferral
    repeat (20) @(posedge clk_sys);
    rd(ADDR_CHANNEL_CONFIG, CFG_RESET);
    rd(4'h6 + 4'($urandom_range(9)), 12'h000);
    wr(ADDR_RESULT_PHASE_ONE, 12'hfff);
    rd(ADDR_RESULT_PHASE_ONE, RESULT_RESET);
    grp(21, 21, 1);
    for (int m = 0; m < 4; m++) begin
      wv = 12'h080 | data_t'(m * 4) | (data_t'($urandom()) & 12'hf70);
      wr(ADDR_CHANNEL_CONFIG, wv);
      repeat (30) @(posedge clk_sys);
      chk(sha_hold, 1'b0);
      rd(ADDR_CHANNEL_CONFIG, wv & CFG_WRITE_MASK);
      cfg_r = wv;
      grp(21, 21, 1);
    end
    grp(21, 21, 0);
    grp(22, 45, 1);
    end_sim();
  end
endmodule

bind adc_sample_sequencer adc_seq_monitor i_adc_seq_monitor (.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n),
  .rd_n(rd_n), .addr(addr), .data_out(data_out), .data_oe(data_oe), .sha_hold(sha_hold),
  .adc_channel(adc_channel), .irq_n(irq_n));
